// File: src/thermo_cfg_defines.vh
`ifndef THERMO_CFG_DEFINES_VH
`define THERMO_CFG_DEFINES_VH

// ----------------------------------------------------------------
// Memory map
// ----------------------------------------------------------------
`define SPACE_RAM 1'b0
`define SPACE_NV 1'b1
`define ADDR_W 5
`define NV_ADDR_SETTINGS 5'h05
`define RAM_ADDR_AMBIENT 5'h06
`define RAM_ADDR_OBJ_ONE 5'h07
`define RAM_ADDR_OBJ_TWO 5'h08
`define RAM_DEPTH 32
`define RAM_W 17
`define CFG_W 16
`define CFG_DEFAULT 16'h0000

// ----------------------------------------------------------------
// Settings word fields
// ----------------------------------------------------------------
`define F_IIR_LO 0
`define F_IIR_HI 2
`define F_AMB_SENSOR 3
`define F_PWM_LO 4
`define F_PWM_HI 5
`define F_DUAL_IR 6
`define F_ALPHA_SIGN 7
`define F_FIR_LO 8
`define F_FIR_HI 10
`define F_GAIN_LO 11
`define F_GAIN_HI 13
`define F_SHOCK_SIGN 15

// ----------------------------------------------------------------
// IIR coefficients as 16-bit fractions of one
// ----------------------------------------------------------------
`define IIR_HALF 16'h8000
`define IIR_4_7 16'h9249
`define IIR_3_7 16'h6db7
`define IIR_2_3 16'haaab
`define IIR_1_3 16'h5555
`define IIR_4_5 16'hcccd
`define IIR_1_5 16'h3333
`define IIR_ONE 16'hffff
`define IIR_ZERO 16'h0000

// ----------------------------------------------------------------
// Pulse-width item codes, FIR base, gain table (gain times two)
// ----------------------------------------------------------------
`define ITEM_AMBIENT 2'h0
`define ITEM_IR_ONE 2'h1
`define ITEM_IR_TWO 2'h2
`define ITEM_NONE 2'h3
`define FIR_LOG2_BASE 4'h3
`define GAIN_X2_1 8'h02
`define GAIN_X2_3 8'h06
`define GAIN_X2_6 8'h0c
`define GAIN_X2_12P5 8'h19
`define GAIN_X2_25 8'h32
`define GAIN_X2_50 8'h64
`define GAIN_X2_100 8'hc8

`endif

// File: src/result_store.v
`timescale 1ns/100ps
`include "thermo_cfg_defines.vh"

// Result memory, written only by the measurement side
module result_store (
    input wire mclk_i,
    input wire meas_we_i,
    input wire [`ADDR_W-1:0] meas_addr_i,
    input wire [`RAM_W-1:0] meas_data_i,
    input wire [`ADDR_W-1:0] rd_addr_i,
    output wire [`RAM_W-1:0] rd_data_o
);
    reg [`RAM_W-1:0] mem [0:`RAM_DEPTH-1];

    // Only the arithmetic side has a write port; the host path cannot reach it
    always @(posedge mclk_i) begin
        if (meas_we_i) begin
            mem[meas_addr_i] <= meas_data_i;
        end
    end

    // Asynchronous read, registered by the caller
    assign rd_data_o = mem[rd_addr_i];
endmodule

// File: src/settings_decode.v
`timescale 1ns/100ps
`include "thermo_cfg_defines.vh"

// Combinational decode of the settings word into working values
module settings_decode (
    input wire [`CFG_W-1:0] cfg_i,
    output reg [15:0] iir_a1_o,
    output reg [15:0] iir_b1_o,
    output wire iir_bypass_o,
    output reg [1:0] item1_o,
    output reg [1:0] item2_o,
    output wire [3:0] fir_log2_o,
    output reg [7:0] gain_x2_o,
    output wire preamp_bypass_o
);
    wire [2:0] iir_code = cfg_i[`F_IIR_HI:`F_IIR_LO];
    wire [2:0] gain_code = cfg_i[`F_GAIN_HI:`F_GAIN_LO];

    always @* begin
        case (iir_code)
            3'h7: begin
                iir_a1_o = `IIR_4_7;
                iir_b1_o = `IIR_3_7;
            end
            3'h6: begin
                iir_a1_o = `IIR_2_3;
                iir_b1_o = `IIR_1_3;
            end
            3'h5: begin
                iir_a1_o = `IIR_4_5;
                iir_b1_o = `IIR_1_5;
            end
            3'h4: begin
                iir_a1_o = `IIR_ONE;
                iir_b1_o = `IIR_ZERO;
            end
            default: begin
                iir_a1_o = `IIR_HALF;
                iir_b1_o = `IIR_HALF;
            end
        endcase
    end
    assign iir_bypass_o = (iir_code == 3'h4);

    always @* begin
        case (cfg_i[`F_PWM_HI:`F_PWM_LO])
            2'h0: begin
                item1_o = `ITEM_AMBIENT;
                item2_o = `ITEM_IR_ONE;
            end
            2'h1: begin
                item1_o = `ITEM_AMBIENT;
                item2_o = `ITEM_IR_TWO;
            end
            2'h3: begin
                item1_o = `ITEM_IR_ONE;
                item2_o = `ITEM_IR_TWO;
            end
            default: begin
                item1_o = `ITEM_IR_TWO;
                item2_o = `ITEM_NONE;
            end
        endcase
    end

    // FIR length is two to the (code plus three)
    assign fir_log2_o = `FIR_LOG2_BASE + {1'b0, cfg_i[`F_FIR_HI:`F_FIR_LO]};

    // Amplifier gain table, top two codes both give 100
    always @* begin
        case (gain_code)
            3'h0: gain_x2_o = `GAIN_X2_1;
            3'h1: gain_x2_o = `GAIN_X2_3;
            3'h2: gain_x2_o = `GAIN_X2_6;
            3'h3: gain_x2_o = `GAIN_X2_12P5;
            3'h4: gain_x2_o = `GAIN_X2_25;
            3'h5: gain_x2_o = `GAIN_X2_50;
            default: gain_x2_o = `GAIN_X2_100;
        endcase
    end
    assign preamp_bypass_o = (gain_code == 3'h0);
endmodule

// File: src/thermo_cfg_map.v
`timescale 1ns/100ps
`include "thermo_cfg_defines.vh"

module thermo_cfg_map (
    input wire mclk_i,
    input wire arst_n_i,
    // Word access from the serial protocol engine
    input wire acc_req_i,
    input wire acc_space_i,
    input wire acc_write_i,
    input wire [`ADDR_W-1:0] acc_addr_i,
    input wire [`CFG_W-1:0] acc_wdata_i,
    output reg acc_ack_o,
    output reg acc_refused_o,
    output reg [`RAM_W-1:0] acc_rdata_o,
    // Stored settings word brought in from the non-volatile array
    input wire nv_load_i,
    input wire [`CFG_W-1:0] nv_settings_i,
    output reg nv_store_o,
    output reg [`CFG_W-1:0] settings_o,
    // Result writes from the temperature arithmetic
    input wire meas_we_i,
    input wire [`ADDR_W-1:0] meas_addr_i,
    input wire [`RAM_W-1:0] meas_data_i,
    // Decoded settings
    output reg [15:0] iir_a1_o,
    output reg [15:0] iir_b1_o,
    output reg iir_bypass_o,
    output reg amb_ptc_sel_o,
    output reg [1:0] pwm_item1_o,
    output reg [1:0] pwm_item2_o,
    output reg pwm_item2_valid_o,
    output reg dual_ir_o,
    output reg alpha_slope_sign_o,
    output reg [3:0] fir_log2_o,
    output reg [10:0] fir_len_o,
    output reg [7:0] gain_x2_o,
    output reg preamp_bypass_o,
    output reg shock_negative_o,
    // Result mirrors for the pulse-width side
    output reg [`RAM_W-1:0] ambient_temperature_o,
    output reg [`RAM_W-1:0] obj_temp_one_o,
    output reg [`RAM_W-1:0] obj_temp_two_o,
    output reg obj_two_active_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Address compare shared by the access and mirror paths
    function addr_is;
        input [`ADDR_W-1:0] a;
        input [`ADDR_W-1:0] b;
        begin
            addr_is = (a == b);
        end
    endfunction

    // FIR length from its log2, kept to eleven bits
    function [10:0] pow2_len;
        input [3:0] sh;
        begin
            pow2_len = 11'h001 << sh;
        end
    endfunction

    // ------------------------------------------------------------
    // Settings word
    // ------------------------------------------------------------

    reg [`CFG_W-1:0] settings_r;
    reg [`CFG_W-1:0] settings_nxt;
    wire host_wr_settings;
    wire host_wr_ram;
    wire host_wr_other;

    assign host_wr_settings = acc_req_i & acc_write_i & (acc_space_i == `SPACE_NV) &
                              addr_is(acc_addr_i, `NV_ADDR_SETTINGS);
    assign host_wr_ram = acc_req_i & acc_write_i & (acc_space_i == `SPACE_RAM);
    assign host_wr_other = acc_req_i & acc_write_i & (acc_space_i == `SPACE_NV) &
                           ~addr_is(acc_addr_i, `NV_ADDR_SETTINGS);

    // Host write wins over a load from the array in the same cycle
    always @* begin
        settings_nxt = settings_r;
        if (nv_load_i) begin
            settings_nxt = nv_settings_i;
        end
        if (host_wr_settings) begin
            settings_nxt = acc_wdata_i;
        end
    end

    // Calibration bits are not guarded; the host must keep them intact
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            settings_r <= `CFG_DEFAULT;
        end else begin
            settings_r <= settings_nxt;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------

    wire [15:0] dec_a1;
    wire [15:0] dec_b1;
    wire dec_bypass;
    wire [1:0] dec_item1;
    wire [1:0] dec_item2;
    wire [3:0] dec_fir_log2;
    wire [7:0] dec_gain_x2;
    wire dec_preamp_bypass;

    // Bit 14 goes to the decoder with the whole word, but no decoded field uses it
    settings_decode u_decode (
        .cfg_i(settings_r),
        .iir_a1_o(dec_a1),
        .iir_b1_o(dec_b1),
        .iir_bypass_o(dec_bypass),
        .item1_o(dec_item1),
        .item2_o(dec_item2),
        .fir_log2_o(dec_fir_log2),
        .gain_x2_o(dec_gain_x2),
        .preamp_bypass_o(dec_preamp_bypass)
    );

    // Registered decode: one cycle behind the settings word, glitch free
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            iir_a1_o <= `IIR_HALF;
            iir_b1_o <= `IIR_HALF;
            iir_bypass_o <= 1'b0;
            amb_ptc_sel_o <= 1'b0;
            pwm_item1_o <= `ITEM_AMBIENT;
            pwm_item2_o <= `ITEM_IR_ONE;
            pwm_item2_valid_o <= 1'b1;
            dual_ir_o <= 1'b0;
            alpha_slope_sign_o <= 1'b0;
            fir_log2_o <= `FIR_LOG2_BASE;
            fir_len_o <= 11'h008;
            gain_x2_o <= `GAIN_X2_1;
            preamp_bypass_o <= 1'b1;
            shock_negative_o <= 1'b0;
        end else begin
            iir_a1_o <= dec_a1;
            iir_b1_o <= dec_b1;
            iir_bypass_o <= dec_bypass;
            amb_ptc_sel_o <= settings_r[`F_AMB_SENSOR];
            pwm_item1_o <= dec_item1;
            pwm_item2_o <= dec_item2;
            pwm_item2_valid_o <= (dec_item2 != `ITEM_NONE);
            dual_ir_o <= settings_r[`F_DUAL_IR];
            alpha_slope_sign_o <= settings_r[`F_ALPHA_SIGN];
            fir_log2_o <= dec_fir_log2;
            fir_len_o <= pow2_len(dec_fir_log2);
            gain_x2_o <= dec_gain_x2;
            preamp_bypass_o <= dec_preamp_bypass;
            shock_negative_o <= settings_r[`F_SHOCK_SIGN];
        end
    end

    // ------------------------------------------------------------
    // Result memory
    // ------------------------------------------------------------

    wire [`RAM_W-1:0] ram_rd_data;

    // 32 by 17 store, host has read access only
    result_store u_results (
        .mclk_i(mclk_i),
        .meas_we_i(meas_we_i),
        .meas_addr_i(meas_addr_i),
        .meas_data_i(meas_data_i),
        .rd_addr_i(acc_addr_i),
        .rd_data_o(ram_rd_data)
    );

    // Mirrors track the arithmetic writes so the output side needs no read port
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ambient_temperature_o <= {`RAM_W{1'b0}};
            obj_temp_one_o <= {`RAM_W{1'b0}};
            obj_temp_two_o <= {`RAM_W{1'b0}};
            obj_two_active_o <= 1'b0;
        end else begin
            if (meas_we_i && addr_is(meas_addr_i, `RAM_ADDR_AMBIENT)) begin
                ambient_temperature_o <= meas_data_i;
            end
            if (meas_we_i && addr_is(meas_addr_i, `RAM_ADDR_OBJ_ONE)) begin
                obj_temp_one_o <= meas_data_i;
            end
            if (meas_we_i && addr_is(meas_addr_i, `RAM_ADDR_OBJ_TWO)) begin
                obj_temp_two_o <= meas_data_i;
            end
            // second object result only counts with two sensors
            obj_two_active_o <= settings_r[`F_DUAL_IR];
        end
    end

    // ------------------------------------------------------------
    // Access answer
    // ------------------------------------------------------------

    reg [`RAM_W-1:0] rdata_nxt;

    // Read mux: result memory word, or the settings word zero extended
    always @* begin
        rdata_nxt = {`RAM_W{1'b0}};
        if (acc_space_i == `SPACE_RAM) begin
            rdata_nxt = ram_rd_data;
        end else if (addr_is(acc_addr_i, `NV_ADDR_SETTINGS)) begin
            // bit 14 reads back as stored
            rdata_nxt = {1'b0, settings_r};
        end
    end

    // One-cycle answer; read data is held until the next read request
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc_ack_o <= 1'b0;
            acc_refused_o <= 1'b0;
            acc_rdata_o <= {`RAM_W{1'b0}};
            nv_store_o <= 1'b0;
            settings_o <= `CFG_DEFAULT;
        end else begin
            acc_ack_o <= acc_req_i;
            // result writes and writes to other non-volatile words are dropped and flagged
            acc_refused_o <= host_wr_ram | host_wr_other;
            if (acc_req_i && !acc_write_i) begin
                acc_rdata_o <= rdata_nxt;
            end
            // Ask the array to commit a new settings word
            nv_store_o <= host_wr_settings;
            settings_o <= settings_nxt;
        end
    end

endmodule

// File: bench/thermo_cfg_map_sva.sv
`timescale 1ns/100ps
`include "thermo_cfg_defines.vh"

// ----
// Port checker for the settings and result map
// ----
module thermo_cfg_map_sva (
    input wire mclk_i,
    input wire arst_n_i,
    input wire acc_req_i,
    input wire acc_space_i,
    input wire acc_write_i,
    input wire [`ADDR_W-1:0] acc_addr_i,
    input wire [`CFG_W-1:0] acc_wdata_i,
    input wire acc_ack_o,
    input wire acc_refused_o,
    input wire nv_store_o,
    input wire [`CFG_W-1:0] settings_o,
    input wire iir_bypass_o,
    input wire amb_ptc_sel_o,
    input wire dual_ir_o,
    input wire [10:0] fir_len_o,
    input wire shock_negative_o,
    input wire meas_we_i,
    input wire [`ADDR_W-1:0] meas_addr_i,
    input wire [`RAM_W-1:0] meas_data_i,
    input wire [`RAM_W-1:0] ambient_temperature_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    // Access answers, one cycle after each request
    a_ack_after_req: assert property (acc_req_i |=> acc_ack_o)
        else $error("ack missing after request");
    a_no_stray_ack: assert property (!acc_req_i |=> !acc_ack_o && !acc_refused_o)
        else $error("ack without request");
    a_ram_write_refused: assert property (acc_req_i && acc_write_i
        && acc_space_i == `SPACE_RAM |=> acc_refused_o)
        else $error("result memory write not refused");
    a_cfg_write_stores: assert property (acc_req_i && acc_write_i && acc_space_i == `SPACE_NV
        && acc_addr_i == `NV_ADDR_SETTINGS |=> nv_store_o && !acc_refused_o
        && settings_o == $past(acc_wdata_i))
        else $error("settings write not stored");
    // Decode trails the settings word by one cycle
    a_iir_bypass_code: assert property (iir_bypass_o == ($past(settings_o[2:0]) == 3'h4))
        else $error("iir bypass wrong");
    a_amb_sensor_sel: assert property (amb_ptc_sel_o == $past(settings_o[3]))
        else $error("ambient sensor select wrong");
    a_dual_ir_sel: assert property (dual_ir_o == $past(settings_o[6]))
        else $error("dual sensor select wrong");
    a_fir_length: assert property (fir_len_o == (11'h008 << $past(settings_o[10:8])))
        else $error("fir length wrong");
    a_shock_sign: assert property (shock_negative_o == $past(settings_o[15]))
        else $error("shock sign wrong");
    a_ambient_mirror: assert property (meas_we_i && meas_addr_i == `RAM_ADDR_AMBIENT
        ##1 !(meas_we_i && meas_addr_i == `RAM_ADDR_AMBIENT)
        |-> ##1 ambient_temperature_o == $past(meas_data_i, 2))
        else $error("ambient mirror wrong");

    c_cfg_write: cover property (acc_req_i && acc_write_i && acc_space_i == `SPACE_NV);
    c_refused: cover property (acc_refused_o);
    c_meas_then_read: cover property (meas_we_i ##[1:8] acc_req_i);
endmodule

bind thermo_cfg_map thermo_cfg_map_sva i_thermo_cfg_map_sva (.mclk_i, .arst_n_i, .acc_req_i,
    .acc_space_i, .acc_write_i, .acc_addr_i, .acc_wdata_i, .acc_ack_o, .acc_refused_o,
    .nv_store_o, .settings_o, .iir_bypass_o, .amb_ptc_sel_o, .dual_ir_o, .fir_len_o,
    .shock_negative_o, .meas_we_i, .meas_addr_i, .meas_data_i, .ambient_temperature_o);

// File: bench/serial_host_model.sv
`timescale 1ns/100ps

// ----
// Serial host: word reads and writes
// ----
module serial_host_model (
    input wire mclk_i,
    input wire acc_ack_o,
    input wire acc_refused_o,
    input wire [16:0] acc_rdata_o,
    output logic acc_req_i = 1'b0,
    output logic acc_space_i = 1'b0,
    output logic acc_write_i = 1'b0,
    output logic [4:0] acc_addr_i = 5'h00,
    output logic [15:0] acc_wdata_i = 16'h0000
);
    // One request cycle, answer sampled once the next edge has landed
    // No extended pulse-width mode here
    task automatic access(input logic sp, input logic wr, input logic [4:0] ad,
                          input logic [15:0] wd, output logic [16:0] rd, output logic [1:0] st);
        @(posedge mclk_i);
        acc_req_i <= 1'b1;
        acc_space_i <= sp;
        acc_write_i <= wr;
        acc_addr_i <= ad;
        acc_wdata_i <= wd;
        @(posedge mclk_i);
        // Released lines show the inverse so stale values cannot pass
        acc_req_i <= 1'b0;
        acc_space_i <= ~sp;
        acc_write_i <= ~wr;
        acc_addr_i <= ~ad;
        acc_wdata_i <= ~wd;
        #1;
        rd = acc_rdata_o;
        st = {acc_ack_o, acc_refused_o};
    endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/100ps
`include "thermo_cfg_defines.vh"

// ----
// Bench for the settings and result map
// ----
module tb_top;
    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] a1;
        logic [15:0] b1;
        logic [3:0] items;
        logic [7:0] gain;
    } row_t;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic nv_load_i = 1'b0;
    logic [15:0] nv_settings_i = 16'h0000;
    logic meas_we_i = 1'b0;
    logic [4:0] meas_addr_i = 5'h00;
    logic [16:0] meas_data_i = 17'h00000;
    wire acc_req_i, acc_space_i, acc_write_i;
    wire [4:0] acc_addr_i;
    wire [15:0] acc_wdata_i;
    logic acc_ack_o, acc_refused_o, nv_store_o, iir_bypass_o, amb_ptc_sel_o;
    logic pwm_item2_valid_o, dual_ir_o, alpha_slope_sign_o, preamp_bypass_o;
    logic shock_negative_o, obj_two_active_o;
    logic [16:0] acc_rdata_o, ambient_temperature_o, obj_temp_one_o, obj_temp_two_o, rd;
    logic [15:0] settings_o, iir_a1_o, iir_b1_o;
    logic [1:0] pwm_item1_o, pwm_item2_o, st;
    logic [3:0] fir_log2_o;
    logic [10:0] fir_len_o;
    logic [7:0] gain_x2_o;
    int n_errors = 0;
    int n_compared = 0;
    // Settings word, coefficients, item pair, gain times two
    row_t rows [8] = '{
        '{16'h0000, 16'h8000, 16'h8000, 4'h1, 8'h02},
        '{16'h8917, 16'h9249, 16'h6db7, 4'h2, 8'h06},
        '{16'h1276, 16'haaab, 16'h5555, 4'h6, 8'h0c},
        '{16'h1b2d, 16'hcccd, 16'h3333, 4'hb, 8'h19},
        '{16'h6484, 16'hffff, 16'h0000, 4'h1, 8'h32},
        '{16'h2d03, 16'h8000, 16'h8000, 4'h1, 8'h64},
        '{16'h3601, 16'h8000, 16'h8000, 4'h1, 8'hc8},
        '{16'h3f00, 16'h8000, 16'h8000, 4'h1, 8'hc8}};

    thermo_cfg_map i_thermo_cfg_map (.*);
    serial_host_model i_serial_host_model (.*);

    task chk(input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task report_and_stop;
        if (n_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Clock and a watchdog well beyond the fewer than a hundred cycles needed
    initial forever #10 mclk_i = ~mclk_i;
    initial begin
        #200000;
        n_errors++;
        report_and_stop;
    end

    // Table rows first, then the awkward cases
    initial begin
        repeat (9) @(posedge mclk_i);
        #1;
        chk({settings_o, gain_x2_o, fir_len_o, acc_ack_o}, {16'h0000, 8'h02, 11'h008, 1'b0});
        @(posedge mclk_i) arst_n_i <= 1'b1;
        foreach (rows[i]) begin
            i_serial_host_model.access(`SPACE_NV, 1'b1, `NV_ADDR_SETTINGS, rows[i].cfg, rd, st);
            chk(st, 2'b10);
            @(posedge mclk_i);
            #1;
            chk({iir_a1_o, iir_b1_o, iir_bypass_o}, {rows[i].a1, rows[i].b1, rows[i].cfg[2:0] == 3'h4});
            chk(amb_ptc_sel_o, rows[i].cfg[3]);
            chk({pwm_item1_o, pwm_item2_o, pwm_item2_valid_o}, {rows[i].items, rows[i].items[1:0] != 2'h3});
            chk({dual_ir_o, obj_two_active_o}, {2{rows[i].cfg[6]}});
            chk({fir_len_o, fir_log2_o}, {11'h008 << rows[i].cfg[10:8], 4'h3 + rows[i].cfg[10:8]});
            chk({gain_x2_o, preamp_bypass_o}, {rows[i].gain, rows[i].cfg[13:11] == 3'h0});
            chk({shock_negative_o, alpha_slope_sign_o}, {rows[i].cfg[15], rows[i].cfg[7]});
            i_serial_host_model.access(`SPACE_NV, 1'b0, `NV_ADDR_SETTINGS, 16'h0000, rd, st);
            chk(rd, {1'b0, rows[i].cfg});
        end
        // Results land from the arithmetic side, then the host tries to overwrite
        @(posedge mclk_i);
        meas_we_i <= 1'b1;
        meas_addr_i <= `RAM_ADDR_AMBIENT;
        meas_data_i <= 17'h1abcd;
        @(posedge mclk_i);
        meas_addr_i <= 5'h1f;
        meas_data_i <= 17'h0f0f1;
        @(posedge mclk_i);
        meas_addr_i <= `RAM_ADDR_OBJ_ONE;
        meas_data_i <= 17'h00111;
        @(posedge mclk_i);
        meas_addr_i <= `RAM_ADDR_OBJ_TWO;
        meas_data_i <= 17'h10222;
        @(posedge mclk_i);
        meas_we_i <= 1'b0;
        #1;
        chk(ambient_temperature_o, 17'h1abcd);
        chk({obj_temp_one_o, obj_temp_two_o}, {17'h00111, 17'h10222});
        i_serial_host_model.access(`SPACE_RAM, 1'b1, `RAM_ADDR_AMBIENT, 16'hffff, rd, st);
        chk(st, 2'b11);
        i_serial_host_model.access(`SPACE_RAM, 1'b0, `RAM_ADDR_AMBIENT, 16'h0000, rd, st);
        chk(rd, 17'h1abcd);
        i_serial_host_model.access(`SPACE_RAM, 1'b0, 5'h1f, 16'h0000, rd, st);
        chk(rd, 17'h0f0f1);
        i_serial_host_model.access(`SPACE_NV, 1'b1, 5'h04, 16'h1234, rd, st);
        chk(st, 2'b11);
        i_serial_host_model.access(`SPACE_NV, 1'b0, 5'h04, 16'h0000, rd, st);
        chk({rd, settings_o}, {17'h00000, rows[7].cfg});
        // Word loaded from the array, decode a cycle later
        @(posedge mclk_i);
        nv_settings_i <= 16'h8004;
        nv_load_i <= 1'b1;
        @(posedge mclk_i);
        nv_load_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk({settings_o, shock_negative_o, iir_bypass_o}, {16'h8004, 1'b1, 1'b1});
        // Reset in mid-run clears the settings word
        @(posedge mclk_i) arst_n_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk({settings_o, gain_x2_o, shock_negative_o}, {16'h0000, 8'h02, 1'b0});
        @(posedge mclk_i) arst_n_i <= 1'b1;
        @(posedge mclk_i);
        report_and_stop;
    end
endmodule
